//--- logic/vpic_pkg.sv
`default_nettype none
package vpic_pkg;

	// sizes
	localparam int NUM_VEC       = 80;
	localparam int NUM_FLAG_REGS = 5;
	localparam int NUM_PRIO_REGS = 21;
	localparam int PRIO_SLOTS    = 84;
	localparam int SLOTS_PER_REG = 4;

	// word indices on the bus (byte address = 4 * index)
	localparam logic [5:0] ADR_CTRL1  = 6'h00;
	localparam logic [5:0] ADR_CTRL2  = 6'h01;
	localparam logic [5:0] ADR_ALU    = 6'h02;
	localparam logic [5:0] ADR_CORE   = 6'h03;
	localparam logic [5:0] ADR_TEST   = 6'h04;
	localparam logic [5:0] ADR_ISTAT  = 6'h05;
	localparam logic [5:0] ADR_IMASK  = 6'h06;
	localparam logic [5:0] ADR_FLAG0  = 6'h08;
	localparam logic [5:0] ADR_EN0    = 6'h10;
	localparam logic [5:0] ADR_PRIO0  = 6'h20;
	localparam logic [5:0] ADR_PRIOZ  = 6'h35;

	// priority registers that do not exist
	localparam logic [4:0] PRIO_ABS_A = 5'h0D;
	localparam logic [4:0] PRIO_ABS_B = 5'h0E;
	localparam logic [4:0] PRIO_ABS_C = 5'h11;
	localparam logic [4:0] PRIO_LAST  = 5'h14;
	localparam logic [15:0] PRIO_FIELD_MASK = 16'h7777;

	// field positions
	localparam int NEST_BIT   = 15;
	localparam int TRAP_LSB   = 1;
	localparam int ALT_BIT    = 15;
	localparam int EXT_POL_LSB = 0;
	localparam int IPL_LSB    = 5;
	localparam int PRIORITY_LEVEL_TOP_BIT_BIT   = 3;
	localparam int EVT_TAKEN  = 0;
	localparam int EVT_TRAP   = 1;
	localparam int TEST_LVL_LSB = 8;

	localparam logic [15:0] REG_RESET = 16'h0000;

	// external request vectors
	localparam logic [6:0] EXT0_VEC = 7'h00;
	localparam logic [6:0] EXT1_VEC = 7'h14;
	localparam logic [6:0] EXT2_VEC = 7'h1D;

	// implemented vectors
	localparam logic [79:0] IMPL_MASK = 80'h210E_4006_22E3_FE1F_3FEF;

	// vector table placement
	localparam logic [23:0] VEC_BASE    = 24'h000014;
	localparam logic [23:0] ALT_OFFSET  = 24'h000100;

	localparam logic [3:0] LVL_USER_MAX = 4'h7;

	typedef struct packed {
		logic [6:0] vec;
		logic [3:0] lvl;
	} vpic_grant_t;

	typedef enum logic [1:0] {
		VPIC_IDLE  = 2'b00,
		VPIC_FETCH = 2'b01,
		VPIC_DONE  = 2'b10
	} vpic_bus_t;

endpackage
`default_nettype wire

//--- logic/vpic_prio_mem.sv
`timescale 1ns/10ps
`default_nettype none
module vpic_prio_mem (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        we,
	input  wire logic [4:0]  waddr,
	input  wire logic [15:0] wdata,
	input  wire logic [4:0]  ra_bus,
	output logic      [15:0] rd_bus,
	input  wire logic [4:0]  ra_scan,
	output logic      [15:0] rd_scan
);
	import vpic_pkg::*;

	logic [15:0] mem_q [NUM_PRIO_REGS];

	wire bus_in  = ra_bus <= PRIO_LAST;
	wire scan_in = ra_scan <= PRIO_LAST;

	// priority word store, cleared on reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_PRIO_REGS; i++) begin
				mem_q[i] <= REG_RESET;
			end
		end else if (we && waddr <= PRIO_LAST) begin
			mem_q[waddr] <= wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_bus  <= REG_RESET;
			rd_scan <= REG_RESET;
		end else begin
			rd_bus  <= bus_in ? mem_q[ra_bus] : REG_RESET;
			rd_scan <= scan_in ? mem_q[ra_scan] : REG_RESET;
		end
	end
endmodule
`default_nettype wire

//--- logic/vpic_scan.sv
`timescale 1ns/10ps
`default_nettype none
module vpic_scan (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic [83:0]           pending,
	input  wire logic [15:0]           prio_word,
	output logic      [4:0]            word_addr,
	output logic                       done,
	output vpic_pkg::vpic_grant_t      best
);
	import vpic_pkg::*;

	logic [4:0]  idx_q;
	logic [4:0]  ev_q;
	logic        ev_ok_q;
	vpic_grant_t best_q;
	vpic_grant_t best_d;

	assign word_addr = idx_q;

	// walk one word of four priorities per cycle
	always_comb begin
		logic [6:0] v;
		logic [3:0] p;
		v = 7'h00;
		p = 4'h0;
		best_d = (ev_q == 5'h00) ? '0 : best_q;
		for (int k = 0; k < SLOTS_PER_REG; k++) begin
			v = 7'({ev_q, 2'b00} + 7'(k));
			p = {1'b0, prio_word[k*4 +: 3]};
			// strict compare keeps the lowest vector on ties
			if (pending[v] && p > best_d.lvl) begin
				best_d.vec = v;
				best_d.lvl = p;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			idx_q   <= 5'h00;
			ev_q    <= 5'h00;
			ev_ok_q <= 1'b0;
			best_q  <= '0;
			done    <= 1'b0;
			best    <= '0;
		end else begin
			idx_q   <= (idx_q == PRIO_LAST) ? 5'h00 : idx_q + 5'h01;
			ev_q    <= idx_q;
			ev_ok_q <= 1'b1;
			if (ev_ok_q) begin
				best_q <= best_d;
			end
			done <= ev_ok_q && ev_q == PRIO_LAST;
			if (ev_ok_q && ev_q == PRIO_LAST) begin
				best <= best_d;
			end
		end
	end
endmodule
`default_nettype wire

//--- logic/vpic_ctrl.sv
// Behaviour
// - each source has a request flag set by its source and cleared only by a software write.
// - each source has an enable; a disabled source never interrupts but its flag still records.
// - each user source has a 3-bit writable priority giving eight levels.
// - flags, enables and priorities are laid out in ascending vector order, vector 0 lowest.
// - natural order equals vector number, external request zero being vector 0.
// - only the defined vectors exist; entry N sits at 0x14 plus 2N, alternate 0x100 higher.
// - a bit of the second control register selects the alternate vector table.
// - the second control register sets how external requests are recognised.
// - the first control register holds nesting disable and the four trap status flags.
// - the low three cpu level bits sit at status bits 7 to 5 and software may write them.
// - the top cpu level bit in the core control register cannot be set by software.
// - a taken request latches its vector and its own priority level into the readable test register.
// - the register set is two controls, five flag, five enable, priorities 0-20 less 13,14,17, test.
// - the full cpu level is the top bit placed above the three status bits.
// - low bits 111 with top bit clear give level 7 and block all user requests.
// - while nesting is disabled the three status level bits are read-only.
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module vpic_ctrl (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic [5:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	input  wire logic [79:0]           src_req,
	input  wire logic [2:0]            ext_irq,
	input  wire logic [3:0]            trap_set,
	input  wire logic                  trap_taken,
	input  wire logic                  cpu_ack,
	output logic                       cpu_irq,
	output vpic_pkg::vpic_grant_t      cpu_grant,
	output logic      [23:0]           vector_addr,
	output logic      [3:0]            cpu_priority_level,
	output logic                       irq
);
	import vpic_pkg::*;

	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] be);
		lane_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic logic [23:0] vec_addr(input logic [6:0] v, input logic alt);
		vec_addr = VEC_BASE + {16'h0000, v, 1'b0} + (alt ? ALT_OFFSET : 24'h000000);
	endfunction

	// bus state
	vpic_bus_t   phase_q;
	logic [15:0] ctrl1_q;
	logic [15:0] ctrl2_q;
	logic [15:0] istat_q;
	logic [15:0] imask_q;
	logic [15:0] test_q;
	logic [15:0] test_d;
	logic [15:0] evt;
	logic [2:0]  ipl_q;
	logic        top_q;
	logic [79:0] flag_q;
	logic [79:0] en_q;
	logic [79:0] flag_d;
	logic [79:0] en_d;
	logic [79:0] flag_set;
	logic [2:0]  ext_q;
	logic [15:0] rd_mux;
	logic        offer_q;
	vpic_grant_t grant_q;

	// decode
	wire         req      = avs_read || avs_write;
	wire         commit   = phase_q == VPIC_DONE;
	wire         wr_ok    = commit && avs_write;
	wire [15:0]  wd       = avs_writedata[15:0];
	wire [1:0]   be       = avs_byteenable[1:0];
	wire [5:0]   prio_off = avs_address - ADR_PRIO0;
	wire [4:0]   prio_idx = prio_off[4:0];
	wire         in_prio  = avs_address >= ADR_PRIO0 && avs_address <= ADR_PRIOZ;
	wire         prio_abs = prio_idx == PRIO_ABS_A || prio_idx == PRIO_ABS_B
		|| prio_idx == PRIO_ABS_C;
	wire         prio_hit = in_prio && !prio_abs;
	wire [5:0]   flag_off = avs_address - ADR_FLAG0;
	wire [5:0]   en_off   = avs_address - ADR_EN0;
	wire         in_flag  = avs_address >= ADR_FLAG0 && flag_off < 6'(NUM_FLAG_REGS);
	wire         in_en    = avs_address >= ADR_EN0 && en_off < 6'(NUM_FLAG_REGS);
	wire         wr_ctrl1 = wr_ok && avs_address == ADR_CTRL1;
	wire         wr_ctrl2 = wr_ok && avs_address == ADR_CTRL2;
	wire         wr_alu   = wr_ok && avs_address == ADR_ALU;
	wire         wr_core  = wr_ok && avs_address == ADR_CORE;
	wire         wr_istat = wr_ok && avs_address == ADR_ISTAT;
	wire         wr_imask = wr_ok && avs_address == ADR_IMASK;
	wire         nest_dis = ctrl1_q[NEST_BIT];
	wire         alt_sel  = ctrl2_q[ALT_BIT];
	wire [2:0]   ext_pol  = ctrl2_q[EXT_POL_LSB +: 3];
	wire [3:0]   cur_lvl  = {top_q, ipl_q};
	wire         take     = cpu_ack && offer_q;

	// priority store and scanner
	logic [15:0] prio_bus_rd;
	logic [15:0] prio_scan_rd;
	logic [4:0]  scan_addr;
	logic        scan_done;
	vpic_grant_t scan_best;
	wire [15:0]  prio_wdata = lane_merge(prio_bus_rd, wd, be) & PRIO_FIELD_MASK;
	wire [83:0]  pending    = {4'h0, flag_q & en_q};

	vpic_prio_mem u_mem (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.we      (wr_ok && prio_hit),
		.waddr   (prio_idx),
		.wdata   (prio_wdata),
		.ra_bus  (prio_idx),
		.rd_bus  (prio_bus_rd),
		.ra_scan (scan_addr),
		.rd_scan (prio_scan_rd)
	);

	vpic_scan u_scan (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.pending   (pending),
		.prio_word (prio_scan_rd),
		.word_addr (scan_addr),
		.done      (scan_done),
		.best      (scan_best)
	);

	// external edge recognition, polarity 1 selects falling edge
	wire [2:0] ext_edge = (ext_pol & ext_q & ~ext_irq) | (~ext_pol & ~ext_q & ext_irq);

	always_comb begin
		flag_set = src_req;
		flag_set[EXT0_VEC] = ext_edge[0];
		flag_set[EXT1_VEC] = ext_edge[1];
		flag_set[EXT2_VEC] = ext_edge[2];
	end

	// flag and enable words, word w covers vectors 16w..16w+15
	always_comb begin
		flag_d = flag_q;
		en_d   = en_q;
		for (int w = 0; w < NUM_FLAG_REGS; w++) begin
			if (wr_ok && in_flag && flag_off == 6'(w)) begin
				flag_d[w*16 +: 16] = lane_merge(flag_q[w*16 +: 16], wd, be);
			end
			if (wr_ok && in_en && en_off == 6'(w)) begin
				en_d[w*16 +: 16] = lane_merge(en_q[w*16 +: 16], wd, be);
			end
		end
		// hardware set wins over a software clear
		flag_d = (flag_d | flag_set) & IMPL_MASK;
		en_d   = en_d & IMPL_MASK;
	end

	// read multiplexer
	always_comb begin
		rd_mux = REG_RESET;
		if (avs_address == ADR_CTRL1) begin
			rd_mux = ctrl1_q;
		end else if (avs_address == ADR_CTRL2) begin
			rd_mux = ctrl2_q;
		end else if (avs_address == ADR_ALU) begin
			rd_mux[IPL_LSB +: 3] = ipl_q;
		end else if (avs_address == ADR_CORE) begin
			rd_mux[PRIORITY_LEVEL_TOP_BIT_BIT] = top_q;
		end else if (avs_address == ADR_TEST) begin
			rd_mux = test_q;
		end else if (avs_address == ADR_ISTAT) begin
			rd_mux = istat_q;
		end else if (avs_address == ADR_IMASK) begin
			rd_mux = imask_q;
		end else if (in_flag) begin
			rd_mux = flag_q[flag_off[2:0]*16 +: 16];
		end else if (in_en) begin
			rd_mux = en_q[en_off[2:0]*16 +: 16];
		end else if (prio_hit) begin
			rd_mux = prio_bus_rd;
		end
	end

	// bus handshake: wait two cycles, answer on the third
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			phase_q         <= VPIC_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			case (phase_q)
				VPIC_IDLE: begin
					avs_waitrequest <= 1'b1;
					if (req) begin
						phase_q <= VPIC_FETCH;
					end
				end
				VPIC_FETCH: begin
					phase_q         <= VPIC_DONE;
					avs_waitrequest <= 1'b0;
					avs_readdata    <= {16'h0000, rd_mux};
				end
				VPIC_DONE: begin
					phase_q         <= VPIC_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					phase_q         <= VPIC_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// flags, enables, external history
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flag_q <= 80'h0;
			en_q   <= 80'h0;
			ext_q  <= 3'h0;
		end else begin
			flag_q <= flag_d;
			en_q   <= en_d;
			ext_q  <= ext_irq;
		end
	end

	// control registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl1_q <= REG_RESET;
			ctrl2_q <= REG_RESET;
		end else begin
			if (wr_ctrl1 && be[1]) begin
				ctrl1_q[NEST_BIT]       <= wd[NEST_BIT];
			end
			if (wr_ctrl1 && be[0]) begin
				ctrl1_q[TRAP_LSB +: 4]  <= wd[TRAP_LSB +: 4] | trap_set;
			end else begin
				ctrl1_q[TRAP_LSB +: 4]  <= ctrl1_q[TRAP_LSB +: 4] | trap_set;
			end
			if (wr_ctrl2 && be[1]) begin
				ctrl2_q[ALT_BIT]          <= wd[ALT_BIT];
			end
			if (wr_ctrl2 && be[0]) begin
				ctrl2_q[EXT_POL_LSB +: 3] <= wd[EXT_POL_LSB +: 3];
			end
		end
	end

	// cpu level bits
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ipl_q <= 3'h0;
			top_q <= 1'b0;
		end else begin
			if (take) begin
				ipl_q <= nest_dis ? LVL_USER_MAX[2:0] : grant_q.lvl[2:0];
			end else if (wr_alu && be[0] && !nest_dis) begin
				ipl_q <= wd[IPL_LSB +: 3];
			end
			// software may only clear the top bit
			if (trap_taken) begin
				top_q <= 1'b1;
			end else if (wr_core && be[0] && !wd[PRIORITY_LEVEL_TOP_BIT_BIT]) begin
				top_q <= 1'b0;
			end
		end
	end

	// test word: level above, vector below
	always_comb begin
		test_d                      = REG_RESET;
		test_d[TEST_LVL_LSB +: 4]   = grant_q.lvl;
		test_d[6:0]                 = grant_q.vec;
	end

	// arbitration result offered to the cpu
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			offer_q     <= 1'b0;
			grant_q     <= '0;
			test_q      <= REG_RESET;
			cpu_irq     <= 1'b0;
			cpu_grant   <= '0;
			vector_addr <= VEC_BASE;
		end else begin
			if (take) begin
				offer_q <= 1'b0;
				cpu_irq <= 1'b0;
				test_q  <= test_d;
			end else if (scan_done) begin
				// level 7 with top bit clear leaves no user level above
				offer_q     <= scan_best.lvl > cur_lvl;
				cpu_irq     <= scan_best.lvl > cur_lvl;
				grant_q     <= scan_best;
				cpu_grant   <= scan_best;
				vector_addr <= vec_addr(scan_best.vec, alt_sel);
			end
		end
	end

	// sticky event status, write one to clear, set wins
	always_comb begin
		evt            = REG_RESET;
		evt[EVT_TAKEN] = take;
		evt[EVT_TRAP]  = |trap_set;
	end

	wire [15:0] istat_d = (wr_istat ? istat_q & ~lane_merge(16'h0000, wd, be) : istat_q) | evt;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			istat_q            <= REG_RESET;
			imask_q            <= REG_RESET;
			irq                <= 1'b0;
			cpu_priority_level <= 4'h0;
		end else begin
			istat_q <= istat_d;
			if (wr_imask) begin
				imask_q <= lane_merge(imask_q, wd, be);
			end
			irq                <= |(istat_d & imask_q);
			cpu_priority_level <= cur_lvl;
		end
	end
endmodule
`default_nettype wire

//--- tb/vpic_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module vpic_cpu_model #(
	parameter int ACK_DELAY = 3
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic ack_en,
	input  wire logic cpu_irq,
	output logic      cpu_ack
);
	logic [3:0] cnt_q;
	// accepts only an offer that stands, after a delay
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !cpu_irq || !ack_en || cpu_ack) begin
			cnt_q   <= 4'h0;
			cpu_ack <= 1'b0;
		end else if (cnt_q == 4'(ACK_DELAY)) begin
			cpu_ack <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

//--- tb/vpic_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
module vpic_ctrl_chk (
	input wire logic                  sys_clk,
	input wire logic                  rst_n,
	input wire logic                  avs_read,
	input wire logic                  avs_write,
	input wire logic [31:0]           avs_readdata,
	input wire logic                  avs_waitrequest,
	input wire logic                  trap_taken,
	input wire logic                  cpu_ack,
	input wire logic                  cpu_irq,
	input wire vpic_pkg::vpic_grant_t cpu_grant,
	input wire logic [23:0]           vector_addr,
	input wire logic [3:0]            cpu_priority_level
);
	import vpic_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	bus_answer_a: assert property (
		$rose(avs_read | avs_write) |-> ##[1:4] !avs_waitrequest)
		else $error("bus answer late");
	wait_pulse_a: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low too long");
	upper_zero_a: assert property (
		!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
		else $error("upper read half set");
	ack_drop_a: assert property (
		cpu_ack && cpu_irq |=> !cpu_irq)
		else $error("offer stands after ack");
	vec_addr_a: assert property (
		cpu_irq |-> (vector_addr == VEC_BASE + 24'({cpu_grant.vec, 1'b0}))
		|| (vector_addr == VEC_BASE + ALT_OFFSET + 24'({cpu_grant.vec, 1'b0})))
		else $error("vector address wrong");
	offer_above_a: assert property (
		$rose(cpu_irq) |-> cpu_grant.lvl > cpu_priority_level)
		else $error("offer not above level");
	zero_prio_a: assert property (
		cpu_irq |-> cpu_grant.lvl != 4'h0)
		else $error("priority zero offered");
	ack_level_a: assert property (
		cpu_ack && cpu_irq |-> ##2 (cpu_priority_level[2:0] == $past(cpu_grant.lvl[2:0], 2)
		|| cpu_priority_level[2:0] == 3'h7))
		else $error("level not taken on ack");
	trap_top_a: assert property (
		trap_taken |-> ##2 cpu_priority_level[3])
		else $error("top level bit not set");
	cover property (cpu_ack && cpu_irq);
	cover property ($rose(cpu_irq));
	cover property (trap_taken);
endmodule
bind vpic_ctrl vpic_ctrl_chk u_chk (
	.sys_clk            (sys_clk),
	.rst_n              (rst_n),
	.avs_read           (avs_read),
	.avs_write          (avs_write),
	.avs_readdata       (avs_readdata),
	.avs_waitrequest    (avs_waitrequest),
	.trap_taken         (trap_taken),
	.cpu_ack            (cpu_ack),
	.cpu_irq            (cpu_irq),
	.cpu_grant          (cpu_grant),
	.vector_addr        (vector_addr),
	.cpu_priority_level (cpu_priority_level)
);
`default_nettype wire

//--- tb/vpic_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
module vpic_ctrl_bench;
	import vpic_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [79:0] src_req = 80'h0;
	logic [2:0]  ext_irq = 3'h0;
	logic [3:0]  trap_set = 4'h0;
	logic        trap_taken = 1'b0;
	logic        cpu_ack;
	logic        ack_en = 1'b0;
	logic        cpu_irq;
	vpic_grant_t cpu_grant;
	logic [23:0] vector_addr;
	logic [3:0]  cpu_priority_level;
	logic        irq;
	logic [31:0] rd;
	int          err_count = 0;
	int          cmp_count = 0;
	logic [5:0]  zero_adr [0:7] = '{ADR_CTRL1, ADR_CTRL2, ADR_ALU, ADR_CORE,
		ADR_TEST, ADR_FLAG0, ADR_EN0, 6'h07};

	always #12.5 sys_clk = ~sys_clk;

	vpic_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .src_req(src_req), .ext_irq(ext_irq),
		.trap_set(trap_set), .trap_taken(trap_taken), .cpu_ack(cpu_ack),
		.cpu_irq(cpu_irq), .cpu_grant(cpu_grant), .vector_addr(vector_addr),
		.cpu_priority_level(cpu_priority_level), .irq(irq));

	vpic_cpu_model #(.ACK_DELAY(5)) cpu (.sys_clk(sys_clk), .rst_n(rst_n),
		.ack_en(ack_en), .cpu_irq(cpu_irq), .cpu_ack(cpu_ack));

	task end_sim;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, err_count);
			if (err_count == 0 && cmp_count > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			cmp_count++;
			if (got !== exp) begin
				err_count++;
				$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	task acc(input logic wr, input logic [5:0] a, input logic [15:0] d);
		int k;
		begin
			@(posedge sys_clk);
			avs_address   <= a;
			avs_write     <= wr;
			avs_read      <= ~wr;
			avs_writedata <= {16'h0000, d};
			k = 0;
			do begin
				@(posedge sys_clk);
				k++;
			end while (avs_waitrequest !== 1'b0 && k < 20);
			rd = avs_readdata;
			avs_read  <= 1'b0;
			avs_write <= 1'b0;
			if (k >= 20) begin
				err_count++;
				end_sim();
			end
		end
	endtask

	task rchk(input logic [5:0] a, input logic [15:0] e);
		begin
			acc(1'b0, a, 16'h0000);
			chk(rd, {16'h0000, e});
		end
	endtask

	task wait_irq(input logic v);
		int k;
		begin
			k = 0;
			do begin
				@(posedge sys_clk);
				k++;
			end while (cpu_irq !== v && k < 100);
			if (k >= 100) begin
				err_count++;
				end_sim();
			end
		end
	endtask

	task idle_chk;
		begin
			repeat (50) @(posedge sys_clk);
			chk({31'h0, cpu_irq}, 32'h0);
		end
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			rchk(zero_adr[i], 16'h0000);
		chk({8'h00, vector_addr}, {8'h00, VEC_BASE});
		$display("reset values done");
		acc(1'b1, ADR_PRIO0, 16'hFFFF);
		rchk(ADR_PRIO0, 16'h7777);
		acc(1'b1, ADR_PRIO0 + 6'h0D, 16'hFFFF);
		rchk(ADR_PRIO0 + 6'h0D, 16'h0000);
		acc(1'b1, ADR_PRIO0, 16'h0030);
		acc(1'b1, ADR_PRIO0 + 6'h01, 16'h0030);
		$display("priority fields done");
		@(posedge sys_clk);
		src_req[1] <= 1'b1;
		src_req[5] <= 1'b1;
		@(posedge sys_clk);
		src_req <= 80'h0;
		rchk(ADR_FLAG0, 16'h0022);
		idle_chk();
		acc(1'b1, ADR_FLAG0, 16'h0020);
		rchk(ADR_FLAG0, 16'h0020);
		@(posedge sys_clk);
		src_req[1] <= 1'b1;
		@(posedge sys_clk);
		src_req <= 80'h0;
		$display("flags done");
		acc(1'b1, ADR_EN0, 16'h0022);
		wait_irq(1'b1);
		chk({21'h0, cpu_grant}, {21'h0, 7'h01, 4'h3});
		chk({8'h00, vector_addr}, 32'h0000_0016);
		acc(1'b1, ADR_CTRL2, 16'h8000);
		repeat (50) @(posedge sys_clk);
		chk({8'h00, vector_addr}, 32'h0000_0116);
		acc(1'b1, ADR_CTRL2, 16'h0000);
		$display("arbitration done");
		acc(1'b1, ADR_IMASK, 16'h0001);
		ack_en <= 1'b1;
		wait_irq(1'b0);
		ack_en <= 1'b0;
		rchk(ADR_TEST, 16'h0301);
		rchk(ADR_ALU, 16'h0060);
		chk({28'h0, cpu_priority_level}, 32'h3);
		chk({31'h0, irq}, 32'h1);
		rchk(ADR_ISTAT, 16'h0001);
		acc(1'b1, ADR_ISTAT, 16'h0001);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		idle_chk();
		rchk(ADR_FLAG0, 16'h0022);
		$display("acknowledge done");
		acc(1'b1, ADR_ALU, 16'h00E0);
		idle_chk();
		acc(1'b1, ADR_CTRL1, 16'h8000);
		acc(1'b1, ADR_ALU, 16'h0000);
		rchk(ADR_ALU, 16'h00E0);
		acc(1'b1, ADR_CTRL1, 16'h0000);
		acc(1'b1, ADR_CORE, 16'h0008);
		rchk(ADR_CORE, 16'h0000);
		@(posedge sys_clk);
		trap_taken <= 1'b1;
		@(posedge sys_clk);
		trap_taken <= 1'b0;
		rchk(ADR_CORE, 16'h0008);
		chk({28'h0, cpu_priority_level}, 32'hF);
		acc(1'b1, ADR_CORE, 16'h0000);
		@(posedge sys_clk);
		trap_set <= 4'hF;
		@(posedge sys_clk);
		trap_set <= 4'h0;
		rchk(ADR_CTRL1, 16'h001E);
		rchk(ADR_ISTAT, 16'h0002);
		$display("level and trap done");
		acc(1'b1, ADR_CTRL2, 16'h0002);
		repeat (3) @(posedge sys_clk);
		ext_irq <= 3'h3;
		rchk(ADR_FLAG0, 16'h0023);
		rchk(ADR_FLAG0 + 6'h01, 16'h0000);
		ext_irq <= 3'h1;
		rchk(ADR_FLAG0 + 6'h01, 16'h0010);
		$display("external inputs done");
		avs_byteenable <= 4'h2;
		acc(1'b1, ADR_IMASK, 16'hFFFF);
		avs_byteenable <= 4'hF;
		rchk(ADR_IMASK, 16'hFF01);
		acc(1'b1, ADR_ALU, 16'h0000);
		acc(1'b1, ADR_CTRL1, 16'h8000);
		ack_en <= 1'b1;
		wait_irq(1'b1);
		wait_irq(1'b0);
		ack_en <= 1'b0;
		rchk(ADR_ALU, 16'h00E0);
		rchk(ADR_TEST, 16'h0301);
		$display("nesting done");
		end_sim();
	end
endmodule
`default_nettype wire
